// *** shared/sig_loss_pkg.sv ***
// Package with register map, field layout and encodings of the signal-loss control block.
package sig_loss_pkg;
    localparam int        DATA_W          = 8;
    localparam int        ADDR_W          = 8;
    localparam logic [7:0] CTRL_OFFSET    = 8'h06;
    localparam logic [7:0] CTRL_RESET     = 8'h20;
    localparam int        THR_HI          = 7;
    localparam int        THR_LO          = 5;
    localparam int        FORCE_BIT       = 4;
    localparam int        NO_SQUELCH_BIT  = 3;
    localparam int        SQUELCH_LOW_BIT = 2;
    localparam int        SPARE_BIT       = 1;
    localparam int        CLK_OUT_BIT     = 0;
    localparam logic [2:0] THR_POWER_DOWN = 3'h7;
    localparam logic [2:0] THR_RESET      = 3'h1;
endpackage : sig_loss_pkg

// *** hdl/thr_decode.sv ***
// Threshold code decoder: picks an alarm hysteresis pair or the detector power-down.
`timescale 1ns/1ns
`default_nettype none
module thr_decode
    import sig_loss_pkg::*;
(
    input  wire logic [2:0] code_i,       // Threshold field.
    output logic      [6:0] assert_sel_o, // One-hot assert/de-assert pair select.
    output logic            pwr_down_o    // Detector powered down on all inputs.
);
    // Code 0 is the lowest pair and each code one step higher; 7 powers down.
    assign pwr_down_o   = (code_i == THR_POWER_DOWN);
    assign assert_sel_o = pwr_down_o ? 7'h00 : 7'(7'h01 << code_i);
endmodule // thr_decode
`default_nettype wire

// *** hdl/sig_loss_ctrl.sv ***
// Signal-loss alarm configuration and clock output enable register with Wishbone slave.
//
// Overview of operation
// - Three-bit code picks alarm hysteresis pair; 000 lowest, resets to 001.
// - Each higher code steps both levels up; 101 and 110 are the top pairs.
// - Code 111 powers down signal-loss detection on every input.
// - Bit 4 set forces the alarm asserted; cleared follows detection.
// - Bit 3 cleared squelches on alarm; set never squelches on alarm.
// - Bit 2 cleared holds squelched data high; resets to zero.
// - Bit 2 set holds squelched data low.
// - Bit 0 cleared, its reset value, keeps clock output buffer disabled.
// - Bit 0 set enables clock output buffer; level set elsewhere.
`timescale 1ns/1ns
`default_nettype none
module sig_loss_ctrl
    import sig_loss_pkg::*;
#(
    parameter int WB_DW = 32
)(
    input  wire logic                      clk_i,          // Core clock, 100 MHz.
    input  wire logic                      rst_i,          // Synchronous reset, high.
    input  wire logic [sig_loss_pkg::ADDR_W-1:0] adr_i,    // Wishbone byte address.
    input  wire logic [WB_DW-1:0]          dat_i,          // Wishbone write data.
    input  wire logic [WB_DW/8-1:0]        sel_i,          // Wishbone byte selects.
    input  wire logic                      we_i,           // Wishbone write enable.
    input  wire logic                      cyc_i,          // Wishbone cycle.
    input  wire logic                      stb_i,          // Wishbone strobe.
    input  wire logic                      detect_i,       // Raw detector alarm.
    input  wire logic                      data_i,         // Serial data in.
    output logic [WB_DW-1:0]               dat_o,          // Wishbone read data.
    output logic                           ack_o,          // Wishbone acknowledge.
    output logic                           err_o,          // Unmapped address.
    output logic [6:0]                     thr_sel_o,      // One-hot hysteresis pair.
    output logic                           det_pwr_down_o, // Detector power-down.
    output logic                           signal_absent_alarm_o, // Alarm out.
    output logic                           data_o,         // Possibly squelched data.
    output logic                           clk_out_en_o    // Clock output buffer enable.
);
    import sig_loss_pkg::*;

    // A narrower bus could not carry the whole register in one beat.
    if (WB_DW < DATA_W || WB_DW % 8 != 0)
    begin : g_bad_width
        $error("Bus width must be a byte multiple of at least 8.");
    end

    // The power-down test is needed by the reset value and by several checks.
    function automatic logic is_power_down(input logic [2:0] code);
        return code == THR_POWER_DOWN;
    endfunction

    // One-hot pair select for a code; the power-down code selects no pair.
    function automatic logic [6:0] thr_onehot(input logic [2:0] code);
        return is_power_down(code) ? 7'h00 : 7'(7'h01 << code);
    endfunction

    logic [7:0] ctrl;
    wire        req      = cyc_i && stb_i && !ack_o && !err_o;
    wire        hit      = (adr_i == CTRL_OFFSET);
    wire        wr_ctrl  = req && hit && we_i && sel_i[0];
    wire [7:0]  next_ctrl = wr_ctrl ? dat_i[7:0] : ctrl;
    wire [6:0]  dec_sel;
    wire        dec_pd;
    wire        alarm    = ctrl[FORCE_BIT] || (detect_i && !dec_pd);
    wire        squelch  = alarm && !ctrl[NO_SQUELCH_BIT];
    wire        held     = !ctrl[SQUELCH_LOW_BIT];

    thr_decode u_dec
    (
        .code_i       (ctrl[THR_HI:THR_LO]),
        .assert_sel_o (dec_sel),
        .pwr_down_o   (dec_pd)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl   <= CTRL_RESET;
            ack_o  <= 1'b0;
            err_o  <= 1'b0;
            dat_o  <= '0;
        end
        else
        begin
            ctrl   <= next_ctrl;
            ack_o  <= req && hit;
            err_o  <= req && !hit;
            dat_o  <= (req && hit) ? WB_DW'(ctrl) : '0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            thr_sel_o             <= thr_onehot(THR_RESET);
            det_pwr_down_o        <= 1'b0;
            signal_absent_alarm_o <= 1'b0;
            data_o                <= 1'b0;
            clk_out_en_o          <= 1'b0;
        end
        else
        begin
            thr_sel_o             <= dec_sel;
            det_pwr_down_o        <= dec_pd;
            signal_absent_alarm_o <= alarm;
            data_o                <= squelch ? held : data_i;
            clk_out_en_o          <= ctrl[CLK_OUT_BIT];
        end
    end

    property p_pwr_down;
        @(posedge clk_i) disable iff (rst_i)
        is_power_down(ctrl[THR_HI:THR_LO]) |=> det_pwr_down_o && thr_sel_o == 7'h00;
    endproperty
    a_pwr_down: assert property (p_pwr_down) else $error("Power-down not applied.");

    property p_thr;
        @(posedge clk_i) disable iff (rst_i)
        !is_power_down(ctrl[THR_HI:THR_LO]) |=>
            thr_sel_o == 7'(7'h01 << $past(ctrl[THR_HI:THR_LO])) && !det_pwr_down_o;
    endproperty
    a_thr: assert property (p_thr) else $error("Threshold select wrong.");

    property p_reset_val;
        @(posedge clk_i) $fell(rst_i) |->
            ctrl == CTRL_RESET && thr_sel_o == thr_onehot(THR_RESET) && !clk_out_en_o;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("Reset value wrong.");

    property p_force;
        @(posedge clk_i) disable iff (rst_i)
        ctrl[FORCE_BIT] |=> signal_absent_alarm_o;
    endproperty
    a_force: assert property (p_force) else $error("Forced alarm missing.");

    property p_no_squelch;
        @(posedge clk_i) disable iff (rst_i)
        ctrl[NO_SQUELCH_BIT] |=> data_o == $past(data_i);
    endproperty
    a_no_squelch: assert property (p_no_squelch) else $error("Squelched when disabled.");

    property p_sq_high;
        @(posedge clk_i) disable iff (rst_i)
        (alarm && !ctrl[NO_SQUELCH_BIT] && !ctrl[SQUELCH_LOW_BIT]) |=> data_o;
    endproperty
    a_sq_high: assert property (p_sq_high) else $error("Squelch not high.");

    property p_sq_low;
        @(posedge clk_i) disable iff (rst_i)
        (alarm && !ctrl[NO_SQUELCH_BIT] && ctrl[SQUELCH_LOW_BIT]) |=> !data_o;
    endproperty
    a_sq_low: assert property (p_sq_low) else $error("Squelch not low.");

    property p_clk_en;
        @(posedge clk_i) disable iff (rst_i)
        ##1 clk_out_en_o == $past(ctrl[CLK_OUT_BIT]);
    endproperty
    a_clk_en: assert property (p_clk_en) else $error("Clock enable mismatch.");

    property p_spare;
        @(posedge clk_i) disable iff (rst_i)
        wr_ctrl |=> ctrl[SPARE_BIT] == $past(dat_i[SPARE_BIT]);
    endproperty
    a_spare: assert property (p_spare) else $error("Spare bit lost.");

    // A register write lands at the edge that raises the acknowledge.
    sequence s_wr_req;
        wr_ctrl;
    endsequence

    sequence s_wr_landed;
        ack_o && !err_o && ctrl == $past(dat_i[7:0]);
    endsequence

    property p_write;
        @(posedge clk_i) disable iff (rst_i)
        s_wr_req |=> s_wr_landed;
    endproperty
    a_write: assert property (p_write) else $error("Register write not applied.");

    sequence s_rd_req;
        req && hit && !we_i;
    endsequence

    sequence s_rd_answer;
        ack_o && dat_o == WB_DW'($past(ctrl));
    endsequence

    property p_read;
        @(posedge clk_i) disable iff (rst_i)
        s_rd_req |=> s_rd_answer;
    endproperty
    a_read: assert property (p_read) else $error("Read data wrong.");

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o && dat_o == '0;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("Acknowledge held too long.");

    property p_unmapped;
        @(posedge clk_i) disable iff (rst_i)
        (req && !hit) |=> err_o && !ack_o && ctrl == $past(ctrl);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused.");

    property p_alarm_follow;
        @(posedge clk_i) disable iff (rst_i)
        (!ctrl[FORCE_BIT] && !is_power_down(ctrl[THR_HI:THR_LO])) |=>
            signal_absent_alarm_o == $past(detect_i);
    endproperty
    a_alarm_follow: assert property (p_alarm_follow) else $error("Alarm not following.");

    property p_alarm_masked;
        @(posedge clk_i) disable iff (rst_i)
        (!ctrl[FORCE_BIT] && is_power_down(ctrl[THR_HI:THR_LO])) |=> !signal_absent_alarm_o;
    endproperty
    a_alarm_masked: assert property (p_alarm_masked) else $error("Alarm while down.");

    property p_clk_off;
        @(posedge clk_i) disable iff (rst_i)
        !ctrl[CLK_OUT_BIT] |=> !clk_out_en_o;
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("Clock buffer not off.");
endmodule // sig_loss_ctrl
`default_nettype wire

// *** bench/sig_loss_ctrl_tb_top.sv ***
// Self-checking bench for the signal-loss control register block.
`timescale 1ns/1ns
`default_nettype none
module sig_loss_ctrl_tb_top;
    import sig_loss_pkg::*;
    logic        clk_i = 1'h0, rst_i = 1'h1, we_i = 1'h0, cyc_i = 1'h0, stb_i = 1'h0;
    logic        detect_i = 1'h0, data_i = 1'h0, e, ack_o, err_o, det_pwr_down_o;
    logic        signal_absent_alarm_o, data_o, clk_out_en_o;
    logic [7:0]  adr_i = 8'h00, q;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic [3:0]  sel_i = 4'h0;
    logic [6:0]  thr_sel_o;
    int          err_count = 0, tests_run = 0;

    always #5 clk_i = ~clk_i;

    sig_loss_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .detect_i(detect_i),
        .data_i(data_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .thr_sel_o(thr_sel_o),
        .det_pwr_down_o(det_pwr_down_o), .signal_absent_alarm_o(signal_absent_alarm_o),
        .data_o(data_o), .clk_out_en_o(clk_out_en_o));

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // No cycle limit here: the watchdog ends a run whose slave never answers.
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        sel_i <= 4'h1;
        do
        begin
            @(posedge clk_i);
        end while (ack_o !== 1'h1 && err_o !== 1'h1);
        q = dat_o[7:0];
        e = err_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        we_i  <= 1'h0;
        repeat (2) @(posedge clk_i);
    endtask

    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #50000;
        err_count++;
        give_verdict();
    end

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        check("thr_sel reset", 32'(thr_sel_o), 32'h02);
        check("clk_out_en reset", 32'(clk_out_en_o), 32'h0);
        wb(1'h0, CTRL_OFFSET, 8'h00);
        check("ctrl reset", 32'(q), 32'(CTRL_RESET));
        check("mapped err", 32'(e), 32'h0);
        detect_i <= 1'h1;
        for (int c = 0; c < 8; c++)
        begin
            wb(1'h1, CTRL_OFFSET, {3'(c), 5'h00});
            check("thr_sel", 32'(thr_sel_o), (c == 7) ? 32'h0 : (32'h1 << c));
            check("pwr_down", 32'(det_pwr_down_o), 32'(c == 7));
            check("alarm detect", 32'(signal_absent_alarm_o), 32'(c != 7));
            check("squelch detect", 32'(data_o), 32'(c != 7));
        end
        detect_i <= 1'h0;
        wb(1'h1, CTRL_OFFSET, 8'h10);
        check("alarm forced", 32'(signal_absent_alarm_o), 32'h1);
        check("squelch high", 32'(data_o), 32'h1);
        data_i <= 1'h1;
        wb(1'h1, CTRL_OFFSET, 8'h14);
        check("squelch low", 32'(data_o), 32'h0);
        data_i <= 1'h0;
        wb(1'h1, CTRL_OFFSET, 8'h18);
        check("no squelch", 32'(data_o), 32'h0);
        data_i <= 1'h1;
        wb(1'h1, CTRL_OFFSET, 8'h03);
        check("alarm normal", 32'(signal_absent_alarm_o), 32'h0);
        check("clk_out_en set", 32'(clk_out_en_o), 32'h1);
        check("data pass", 32'(data_o), 32'h1);
        wb(1'h1, 8'h07, 8'hFF);
        check("unmapped err", 32'(e), 32'h1);
        wb(1'h0, CTRL_OFFSET, 8'h00);
        check("spare readback", 32'(q), 32'h03);
        give_verdict();
    end
endmodule // sig_loss_ctrl_tb_top
`default_nettype wire
